// ### flash_sec_map.svh
// Offsets, field positions, reset values and timing counts of the flash security block
// Notes on behaviour
// - Programmed encryption array encrypts verify output
// - Verify data is XNORed with array byte
// - All lock bits one: no lock
// - Level two: block external code reads, latch access
// - Level three: also no verify, no data moves
// - Third lock bit zero: no external execution
// - Lock bits stay until mass erase or reset
// - Option bit three sets watchdog power-up default
// - Other option bits read as one
// - Option byte read at FCh by special read
// - Option byte erased and programmed alone
// - Loader or parallel mode returns signature bytes
// - Reset high, access low, strobe low: loader
// - Loader mode holds while entry condition holds
// - Loader mode fetches from internal loader ROM
// - Loader measures serial baud rate automatically
// - External access pin low forces external fetch
// - Vectors live in lowest 128 bytes
// - Two 8kB banks, sequenced and timed
// - Lock read gives bits at 40h, low three
// - Mass erase returns everything to FFh
// - Stricter lock bit programs the weaker ones
`ifndef FLASH_SEC_MAP_SVH
`define FLASH_SEC_MAP_SVH
// Register byte offsets
`define REG_CMD        8'h00
`define REG_ADDR       8'h04
`define REG_WDATA      8'h08
`define REG_RDATA      8'h0c
`define REG_STATUS     8'h10
`define REG_CTRL       8'h14
`define REG_BAUD       8'h18
`define REG_BANK       8'h1c
// Control field positions
`define CTRL_PAR_MODE  0
`define CTRL_ERR_CLR   1
// Special addresses
`define ADR_SIG_MAKER  8'h30
`define ADR_SIG_PART   8'h31
`define ADR_SIG_EXT    8'h60
`define ADR_LOCK       8'h40
`define ADR_OPTION     8'hfc
// Erased values and option layout
`define ERASED_BYTE    8'hff
`define ERASED_LOCK    3'b111
`define OPT_WDT_BIT    3
`define OPT_UNDEF_ONES 8'hf7
`define VECTOR_TOP     14'h0080
`define INT_SIZE       16'h4000
// Timing
`define CLK_MHZ        250
`define BYTE_PROG_US   100
`define ERASE_MS       828
`define BYTE_PROG_CYC  (`BYTE_PROG_US * `CLK_MHZ)
`define ERASE_CYC      (`ERASE_MS * 1000 * `CLK_MHZ)
`endif

// ### flash_sec_pkg.sv
// Types shared by the flash security block
package flash_sec_pkg;
   typedef enum logic [3:0] {
      CMD_NONE       = 4'h0,
      CMD_MASS_ERASE = 4'h1,
      CMD_WRITE_PROG = 4'h2,
      CMD_READ_PROG  = 4'h3,
      CMD_WRITE_ENC  = 4'h4,
      CMD_WRITE_LB1  = 4'h5,
      CMD_WRITE_LB2  = 4'h6,
      CMD_WRITE_LB3  = 4'h7,
      CMD_READ_LOCK  = 4'h8,
      CMD_WRITE_OPT  = 4'h9,
      CMD_ERASE_OPT  = 4'ha,
      CMD_READ_SPEC  = 4'hb
   } flash_cmd_t;
   // Gray codes along idle, read, pulse, done
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_READ  = 2'b01,
      SEQ_PULSE = 2'b11,
      SEQ_DONE  = 2'b10
   } seq_state_t;
   typedef logic [1:0] prot_level_t;  // 0..3 for levels one..four
endpackage : flash_sec_pkg

// ### verify_scrambler.sv
// Encryption array storage and XNOR scrambling of verify data
`timescale 1ns/1ps
`include "flash_sec_map.svh"
module verify_scrambler
   import flash_sec_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic       wr_in,        // Program one array byte
   input  wire logic       erase_in,     // Mass erase
   input  wire logic [5:0] idx_in,       // Array index
   input  wire logic [7:0] wdata_in,
   input  wire logic [7:0] raw_in,       // Raw program byte
   output logic      [7:0] cooked_out,   // Byte as shown by verify
   output logic            active_out    // Array holds a non-erased byte
);
   logic [7:0] key_mem [64];  // Array in flip-flops
   logic [63:0] erased_vec;   // Per-byte erased flags
   // Storage; flash bits only clear, never set, except by erase or reset
   always_ff @(posedge clk_in)
   begin
      if (rst_in || (ce_in && erase_in))
      begin
         for (int i = 0; i < 64; i++)
            key_mem[i] <= `ERASED_BYTE;
      end
      else if (ce_in && wr_in)
         key_mem[idx_in] <= key_mem[idx_in] & wdata_in;
   end
   always_comb
   begin
      for (int i = 0; i < 64; i++)
         erased_vec[i] = (key_mem[i] == `ERASED_BYTE);
   end
   assign active_out = ~&erased_vec;
   assign cooked_out = active_out ? ~(raw_in ^ key_mem[idx_in]) : raw_in;
endmodule : verify_scrambler

// ### auto_baud_meter.sv
// Measures the start-bit width of the first character seen in loader mode
`timescale 1ns/1ps
module auto_baud_meter
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        arm_in,    // Loader mode
   input  wire logic        rx_in,     // Serial receive pin
   output logic      [15:0] div_out,   // Clocks per bit
   output logic             valid_out  // Measurement taken
);
   logic rx_prev_reg;      // Previous receive level
   logic meas_reg;         // Inside the start bit
   // Count saturates so a stuck line cannot wrap into a bogus rate
   always_ff @(posedge clk_in)
   begin
      if (rst_in || (ce_in && !arm_in))
      begin
         rx_prev_reg <= 1'b1;
         meas_reg    <= 1'b0;
         div_out     <= 16'h0000;
         valid_out   <= 1'b0;
      end
      else if (ce_in)
      begin
         rx_prev_reg <= rx_in;
         if (!valid_out && !meas_reg && rx_prev_reg && !rx_in)
         begin
            meas_reg <= 1'b1;
            div_out  <= 16'h0001;
         end
         else if (meas_reg && !rx_in)
            div_out <= (div_out == 16'hffff) ? div_out : div_out + 16'h0001;
         else if (meas_reg)
         begin
            meas_reg  <= 1'b0;
            valid_out <= 1'b1;
         end
      end
   end
endmodule : auto_baud_meter

// ### flash_security.sv
// Flash security, option byte, programming sequencer and loader entry
`timescale 1ns/1ps
`include "flash_sec_map.svh"
module flash_security
   import flash_sec_pkg::*;
#(
   parameter logic [27:0] BYTE_PROG_CYCLES = 28'(`BYTE_PROG_CYC),
   parameter logic [27:0] ERASE_CYCLES     = 28'(`ERASE_CYC),
   parameter logic [7:0]  SIG_MAKER        = 8'h3c,  // Arbitrary value
   parameter logic [7:0]  SIG_PART         = 8'h7e,  // Arbitrary value
   parameter logic [7:0]  SIG_EXT          = 8'h09   // Arbitrary value
)
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic        CE_IN,
   // Wishbone slave
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [7:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output logic      [31:0] WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   // Pins
   input  wire logic        RESET_PIN_IN,
   input  wire logic        EXTERNAL_ACCESS_PIN_N_IN,
   input  wire logic        PROGRAM_STORE_STROBE_N_IN,
   input  wire logic        SERIAL_RX_IN,
   // Core fetch and data path
   input  wire logic [15:0] CORE_ADDR_IN,
   input  wire logic        CORE_EXEC_EXT_IN,
   input  wire logic        CORE_CODE_READ_IN,
   input  wire logic        CORE_XDATA_READ_IN,
   output logic             FETCH_EXTERNAL_OUT,
   output logic             FETCH_LOADER_ROM_OUT,
   output logic             CODE_READ_BLOCK_OUT,
   output logic             XDATA_READ_BLOCK_OUT,
   output logic             EXT_EXEC_BLOCK_OUT,
   output logic             WDT_POR_DISABLE_OUT,
   output logic [15:0]      BAUD_DIV_OUT,
   // Program flash array
   output logic [13:0]      FLASH_ADDR_OUT,
   output logic             FLASH_BANK_OUT,
   output logic [7:0]       FLASH_WDATA_OUT,
   output logic             FLASH_RD_OUT,
   output logic             FLASH_PROG_OUT,
   output logic             FLASH_ERASE_OUT,
   input  wire logic [7:0]  FLASH_RDATA_IN
);
   // Strictest level wins
   function automatic prot_level_t level_of(input logic [2:0] lb);
      if (!lb[2])
         return 2'd3;
      else if (!lb[1])
         return 2'd2;
      else if (!lb[0])
         return 2'd1;
      else
         return 2'd0;
   endfunction : level_of

   logic [2:0]  lock_reg;      // {third, second, first}
   logic [7:0]  option_reg;    // Option byte flash cells
   logic [7:0]  bank_reg;      // Bank select byte
   logic [13:0] addr_reg;      // Command address
   logic [7:0]  wdata_reg;     // Command write data
   logic [7:0]  rdata_reg;     // Last read result
   flash_cmd_t  cmd_reg;       // Command in flight
   seq_state_t  state_reg;     // Sequencer state
   logic [27:0] count_reg;     // Pulse timer
   logic        error_reg;     // Sticky refusal flag
   logic        par_mode_reg;  // Parallel programming mode
   logic        ea_latch_reg;  // Access pin caught after reset
   logic        ea_taken_reg;  // Catch done
   logic        loader_reg;    // Loader mode
   logic        key_wr_reg;    // Array write strobe
   logic        key_erase_reg; // Array erase strobe
   logic [7:0]  cooked;        // Verify byte after scrambling
   logic        enc_active;    // Array programmed
   logic        baud_valid;    // Rate measured

   // Decoding
   wire         wb_req     = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
   wire         wb_wr      = wb_req && WB_WE_IN && WB_SEL_IN[0];
   prot_level_t level;
   assign level = level_of(lock_reg);
   wire         lvl2       = (level != 2'd0);
   wire         lvl3       = (level >= 2'd2);
   wire         lvl4       = (level == 2'd3);
   wire         ea_low     = lvl2 ? ea_latch_reg : !EXTERNAL_ACCESS_PIN_N_IN;
   wire         loader_cond = RESET_PIN_IN && !EXTERNAL_ACCESS_PIN_N_IN
                              && !PROGRAM_STORE_STROBE_N_IN;
   wire         busy       = (state_reg != SEQ_IDLE);
   wire         cmd_wr     = wb_wr && (WB_ADR_IN == `REG_CMD);
   wire [3:0]   cmd_code   = WB_DAT_IN[3:0];
   wire         is_write   = (cmd_code == CMD_WRITE_PROG) || (cmd_code == CMD_WRITE_ENC)
                             || (cmd_code == CMD_WRITE_OPT) || (cmd_code == CMD_ERASE_OPT);
   wire         is_lock    = (cmd_code == CMD_WRITE_LB1) || (cmd_code == CMD_WRITE_LB2)
                             || (cmd_code == CMD_WRITE_LB3);
   wire         is_pulse   = is_write || is_lock || (cmd_code == CMD_MASS_ERASE);
   wire         special_ok = loader_reg || par_mode_reg;
   // Writes refused from level two, verify from three
   wire         refuse     = busy || (is_write && lvl2)
                             || ((cmd_code == CMD_READ_PROG) && lvl3)
                             || ((cmd_code == CMD_READ_SPEC) && !special_ok)
                             || (cmd_code > CMD_READ_SPEC) || (cmd_code == CMD_NONE);
   wire         accept     = cmd_wr && !refuse;
   wire [7:0]   opt_view   = `OPT_UNDEF_ONES | option_reg;
   wire [7:0]   lock_view  = {5'b00000, lock_reg};
   wire [7:0]   low_addr   = WB_DAT_IN[7:0];
   logic [7:0]  spec_data;
   assign spec_data = (addr_reg[7:0] == `ADR_SIG_MAKER) ? SIG_MAKER :
                      (addr_reg[7:0] == `ADR_SIG_PART)  ? SIG_PART  :
                      (addr_reg[7:0] == `ADR_SIG_EXT)   ? SIG_EXT   :
                      (addr_reg[7:0] == `ADR_LOCK)      ? lock_view :
                      (addr_reg[7:0] == `ADR_OPTION)    ? opt_view  :
                      `ERASED_BYTE;
   wire         pulse_end  = (state_reg == SEQ_PULSE) && (count_reg == 28'h0000001);
   wire [27:0]  pulse_len  = (cmd_code == CMD_MASS_ERASE || cmd_code == CMD_ERASE_OPT)
                             ? ERASE_CYCLES : BYTE_PROG_CYCLES;
   wire         err_clr    = wb_wr && (WB_ADR_IN == `REG_CTRL) && WB_DAT_IN[`CTRL_ERR_CLR];
   // Register read mux
   logic [31:0] rd_mux;
   assign rd_mux = (WB_ADR_IN == `REG_CMD)    ? {28'h0000000, cmd_reg} :
                   (WB_ADR_IN == `REG_ADDR)   ? {18'h00000, addr_reg} :
                   (WB_ADR_IN == `REG_WDATA)  ? {24'h000000, wdata_reg} :
                   (WB_ADR_IN == `REG_RDATA)  ? {24'h000000, rdata_reg} :
                   (WB_ADR_IN == `REG_STATUS) ? {20'h00000, option_reg[`OPT_WDT_BIT],
                                                 ea_latch_reg, level, 1'b0, lock_reg,
                                                 enc_active, loader_reg, error_reg, busy} :
                   (WB_ADR_IN == `REG_CTRL)   ? {31'h00000000, par_mode_reg} :
                   (WB_ADR_IN == `REG_BAUD)   ? {15'h0000, baud_valid, BAUD_DIV_OUT} :
                   (WB_ADR_IN == `REG_BANK)   ? {24'h000000, bank_reg} :
                   32'h00000000;

   verify_scrambler u_scrambler
   (
      .clk_in     (CORE_CLK_IN),
      .rst_in     (RST_IN),
      .ce_in      (CE_IN),
      .wr_in      (key_wr_reg),
      .erase_in   (key_erase_reg),
      .idx_in     (addr_reg[5:0]),
      .wdata_in   (wdata_reg),
      .raw_in     (FLASH_RDATA_IN),
      .cooked_out (cooked),
      .active_out (enc_active)
   );

   auto_baud_meter u_baud
   (
      .clk_in    (CORE_CLK_IN),
      .rst_in    (RST_IN),
      .ce_in     (CE_IN),
      .arm_in    (loader_reg),
      .rx_in     (SERIAL_RX_IN),
      .div_out   (BAUD_DIV_OUT),
      .valid_out (baud_valid)
   );

   // Bus slave: ack one cycle after request
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         WB_ACK_OUT <= 1'b0;
         WB_DAT_OUT <= 32'h00000000;
      end
      else if (CE_IN)
      begin
         WB_ACK_OUT <= wb_req;
         WB_DAT_OUT <= wb_req ? rd_mux : 32'h00000000;
      end
   end

   // Software-written fields; address and data frozen while busy
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         addr_reg     <= 14'h0000;
         wdata_reg    <= 8'h00;
         par_mode_reg <= 1'b0;
      end
      else if (CE_IN && wb_wr && !busy)
      begin
         if (WB_ADR_IN == `REG_ADDR)
            addr_reg <= WB_DAT_IN[13:0];
         else if (WB_ADR_IN == `REG_WDATA)
            wdata_reg <= WB_DAT_IN[7:0];
         else if (WB_ADR_IN == `REG_CTRL)
            par_mode_reg <= WB_DAT_IN[`CTRL_PAR_MODE];
      end
   end

   // Refusal flag; set beats clear
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         error_reg <= 1'b0;
      else if (CE_IN && cmd_wr && refuse)
         error_reg <= 1'b1;
      else if (CE_IN && err_clr)
         error_reg <= 1'b0;
   end

   // Access pin caught once after reset
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         ea_taken_reg <= 1'b0;
         ea_latch_reg <= 1'b0;
      end
      else if (CE_IN && !ea_taken_reg)
      begin
         ea_taken_reg <= 1'b1;
         ea_latch_reg <= !EXTERNAL_ACCESS_PIN_N_IN;
      end
   end

   // Loader mode follows the pin condition; no separate exit path
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         loader_reg <= 1'b0;
      else if (CE_IN)
         loader_reg <= loader_cond;
   end

   // Sequencer: program reads take two cycles, writes and erases a timed pulse
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         state_reg <= SEQ_IDLE;
         cmd_reg   <= CMD_NONE;
         count_reg <= 28'h0000000;
         rdata_reg <= 8'h00;
      end
      else if (CE_IN)
      begin
         case (state_reg)
            SEQ_IDLE:
            begin
               if (accept)
               begin
                  cmd_reg <= flash_cmd_t'(cmd_code);
                  if (cmd_code == CMD_READ_PROG)
                     state_reg <= SEQ_READ;
                  else if (cmd_code == CMD_READ_LOCK)
                     rdata_reg <= lock_view;
                  else if (cmd_code == CMD_READ_SPEC)
                     rdata_reg <= spec_data;
                  else if (is_pulse)
                  begin
                     state_reg <= SEQ_PULSE;
                     count_reg <= pulse_len;
                  end
               end
            end
            SEQ_READ:
               state_reg <= SEQ_DONE;
            SEQ_PULSE:
            begin
               count_reg <= count_reg - 28'h0000001;
               if (pulse_end)
                  state_reg <= SEQ_DONE;
            end
            SEQ_DONE:
            begin
               if (cmd_reg == CMD_READ_PROG)
                  rdata_reg <= cooked;
               state_reg <= SEQ_IDLE;
            end
            default:
               state_reg <= SEQ_IDLE;
         endcase
      end
   end

   // Security cells change only at the end of their pulse; the bank byte also on a bus write
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         lock_reg   <= `ERASED_LOCK;
         option_reg <= `ERASED_BYTE;
         bank_reg   <= `ERASED_BYTE;
      end
      else if (CE_IN && pulse_end)
      begin
         if (cmd_reg == CMD_MASS_ERASE)
         begin
            lock_reg   <= `ERASED_LOCK;
            option_reg <= `ERASED_BYTE;
            bank_reg   <= `ERASED_BYTE;
         end
         // Only zeros are written, so the level can only tighten
         else if (cmd_reg == CMD_WRITE_LB1)
            lock_reg <= lock_reg & 3'b110;
         else if (cmd_reg == CMD_WRITE_LB2)
            lock_reg <= lock_reg & 3'b100;
         else if (cmd_reg == CMD_WRITE_LB3)
            lock_reg <= 3'b000;
         else if (cmd_reg == CMD_WRITE_OPT)
            option_reg <= option_reg & wdata_reg;
         else if (cmd_reg == CMD_ERASE_OPT)
            option_reg <= `ERASED_BYTE;
      end
      else if (CE_IN && wb_wr && (WB_ADR_IN == `REG_BANK) && !loader_reg && !busy)
         bank_reg <= WB_DAT_IN[7:0];  // Fixed in loader mode
   end

   // Strobes to both arrays
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         FLASH_ADDR_OUT  <= 14'h0000;
         FLASH_BANK_OUT  <= 1'b0;
         FLASH_WDATA_OUT <= 8'hff;
         FLASH_RD_OUT    <= 1'b0;
         FLASH_PROG_OUT  <= 1'b0;
         FLASH_ERASE_OUT <= 1'b0;
         key_wr_reg      <= 1'b0;
         key_erase_reg   <= 1'b0;
      end
      else if (CE_IN)
      begin
         FLASH_ADDR_OUT  <= addr_reg;
         FLASH_BANK_OUT  <= addr_reg[13];
         FLASH_WDATA_OUT <= wdata_reg;
         FLASH_RD_OUT    <= accept && (cmd_code == CMD_READ_PROG);
         FLASH_PROG_OUT  <= (state_reg == SEQ_PULSE) && !pulse_end
                            && (cmd_reg == CMD_WRITE_PROG);
         FLASH_ERASE_OUT <= (state_reg == SEQ_PULSE) && !pulse_end
                            && (cmd_reg == CMD_MASS_ERASE);
         key_wr_reg      <= pulse_end && (cmd_reg == CMD_WRITE_ENC);
         key_erase_reg   <= pulse_end && (cmd_reg == CMD_MASS_ERASE);
      end
   end

   // Core access checks, one cycle late
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         FETCH_EXTERNAL_OUT   <= 1'b0;
         FETCH_LOADER_ROM_OUT <= 1'b0;
         CODE_READ_BLOCK_OUT  <= 1'b0;
         XDATA_READ_BLOCK_OUT <= 1'b0;
         EXT_EXEC_BLOCK_OUT   <= 1'b0;
         WDT_POR_DISABLE_OUT  <= 1'b1;
      end
      else if (CE_IN)
      begin
         // Pin low overrides all
         FETCH_EXTERNAL_OUT   <= ea_low
                                 || (CORE_ADDR_IN >= `INT_SIZE);
         FETCH_LOADER_ROM_OUT <= loader_reg;
         CODE_READ_BLOCK_OUT  <= lvl2 && CORE_EXEC_EXT_IN && CORE_CODE_READ_IN
                                 && (CORE_ADDR_IN < `INT_SIZE);
         XDATA_READ_BLOCK_OUT <= lvl3 && CORE_EXEC_EXT_IN && CORE_XDATA_READ_IN;
         EXT_EXEC_BLOCK_OUT   <= lvl4 && CORE_EXEC_EXT_IN;
         WDT_POR_DISABLE_OUT  <= option_reg[`OPT_WDT_BIT];
      end
   end
endmodule : flash_security

// ### flash_security_asserts.sv
// Port-level assertions for the flash security block
`timescale 1ns/1ps
module flash_security_asserts
(
   input wire logic        CORE_CLK_IN,
   input wire logic        RST_IN,
   input wire logic        CE_IN,
   input wire logic        WB_CYC_IN,
   input wire logic        WB_STB_IN,
   input wire logic        WB_ACK_OUT,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic        RESET_PIN_IN,
   input wire logic        EXTERNAL_ACCESS_PIN_N_IN,
   input wire logic        PROGRAM_STORE_STROBE_N_IN,
   input wire logic        FETCH_LOADER_ROM_OUT,
   input wire logic        FLASH_RD_OUT,
   input wire logic [13:0] FLASH_ADDR_OUT,
   input wire logic        FLASH_BANK_OUT,
   input wire logic        WDT_POR_DISABLE_OUT
);
   default clocking dc @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   // Loader entry pattern on the pins
   wire ent = RESET_PIN_IN & ~EXTERNAL_ACCESS_PIN_N_IN & ~PROGRAM_STORE_STROBE_N_IN;
   chk_ack_after_req: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && CE_IN |=> WB_ACK_OUT)
      else $error("no ack");
   chk_ack_one_cycle: assert property (WB_ACK_OUT && CE_IN |=> !WB_ACK_OUT)
      else $error("ack too long");
   chk_data_idle_zero: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
      else $error("data without ack");
   chk_loader_entry: assert property ((ent && CE_IN)[*3] |-> FETCH_LOADER_ROM_OUT)
      else $error("no loader rom");
   chk_loader_exit: assert property ((!ent && CE_IN)[*3] |-> !FETCH_LOADER_ROM_OUT)
      else $error("loader rom kept");
   chk_read_pulse: assert property (FLASH_RD_OUT && CE_IN |=> !FLASH_RD_OUT)
      else $error("read strobe long");
   chk_bank_bit: assert property (FLASH_BANK_OUT == FLASH_ADDR_OUT[13])
      else $error("bank wrong");
   chk_wdt_reset: assert property ($fell(RST_IN) |-> WDT_POR_DISABLE_OUT)
      else $error("wdt default wrong");
endmodule : flash_security_asserts
bind flash_security flash_security_asserts i_chk (.*);

// ### flash_array_model.sv
// Behavioural program flash array
`timescale 1ns/1ps
module flash_array_model
(
   input  wire logic        clk_in,
   input  wire logic [13:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        rd_in,
   input  wire logic        prog_in,
   input  wire logic        erase_in,
   output logic      [7:0]  rdata_out
);
   logic [7:0] mem [16384];      // Cells, erased at start
   logic       prog_d, erase_d;  // Last strobes
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hff;
      {prog_d, erase_d, rdata_out} = 10'h0a5;
   end
   // Data after the strobe, else toggled so stale data fails
   always @(posedge clk_in)
   begin
      prog_d <= prog_in;
      erase_d <= erase_in;
      rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
      if (prog_d && !prog_in) mem[addr_in] <= mem[addr_in] & wdata_in;
      if (erase_d && !erase_in) foreach (mem[i]) mem[i] <= 8'hff;
   end
endmodule : flash_array_model

// ### flash_security_test.sv
// Self-checking bench for the flash security block
`timescale 1ns/1ps
`include "flash_sec_map.svh"
module flash_security_test
   import flash_sec_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, frd, fpr, fer;
   logic        rpin = 1'b0, ea_n = 1'b1, ps_n = 1'b1, rx = 1'b1, rom, fext, eblk, wdt;
   logic        cext = 1'b0, ccode = 1'b0, cxd = 1'b0, xblk, cblk;
   logic [7:0]  adr = 8'h00, fw, frdat, d, e;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [15:0] caddr = 16'h0, baud;
   logic [13:0] fa, a;
   logic [7:0]  sa [5] = '{8'h30, 8'h31, 8'h60, 8'h40, 8'hfc};  // Special places
   logic [7:0]  se [5] = '{8'h3c, 8'h7e, 8'h09, 8'h07, 8'hff};
   int          n_fail, checked, cycles, n;
   flash_security #(.BYTE_PROG_CYCLES(28'd4), .ERASE_CYCLES(28'd8)) i_dut (
      .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat),
      .WB_ACK_OUT(ack), .RESET_PIN_IN(rpin), .EXTERNAL_ACCESS_PIN_N_IN(ea_n),
      .PROGRAM_STORE_STROBE_N_IN(ps_n), .SERIAL_RX_IN(rx), .CORE_ADDR_IN(caddr),
      .CORE_EXEC_EXT_IN(cext), .CORE_CODE_READ_IN(ccode), .CORE_XDATA_READ_IN(cxd),
      .FETCH_EXTERNAL_OUT(fext), .FETCH_LOADER_ROM_OUT(rom), .CODE_READ_BLOCK_OUT(cblk),
      .XDATA_READ_BLOCK_OUT(xblk), .EXT_EXEC_BLOCK_OUT(eblk), .WDT_POR_DISABLE_OUT(wdt),
      .BAUD_DIV_OUT(baud), .FLASH_ADDR_OUT(fa), .FLASH_BANK_OUT(), .FLASH_WDATA_OUT(fw),
      .FLASH_RD_OUT(frd), .FLASH_PROG_OUT(fpr), .FLASH_ERASE_OUT(fer), .FLASH_RDATA_IN(frdat));
   flash_array_model i_flash (.clk_in(clk), .addr_in(fa), .wdata_in(fw), .rd_in(frd),
      .prog_in(fpr), .erase_in(fer), .rdata_out(frdat));
   initial
   begin
      forever #2 clk = ~clk;
   end
   // Random core traffic; hang guard
   always @(posedge clk)
   begin
      {caddr, cext, ccode, cxd} <= 19'($urandom);
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", s, x, g);
      end
   endtask : cmp
   // Classic bus cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, ad, dt};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask : wb
   // Issue a command, wait out busy, fetch read data
   task automatic run(input logic [3:0] c, input logic [13:0] ad, input logic [7:0] dt);
      wb(1'b1, `REG_ADDR, 32'(ad));
      wb(1'b1, `REG_WDATA, 32'(dt));
      wb(1'b1, `REG_CMD, 32'(c));
      repeat (40)
      begin
         wb(1'b0, `REG_STATUS, 0);
         if (q[0] === 1'b0) break;
      end
      wb(1'b0, `REG_RDATA, 0);
   endtask : run
   task automatic lock_chk(input logic [2:0] x);
      wb(1'b0, `REG_STATUS, 0);
      cmp("lock", x, q[6:4]);
      cmp("level", !x[2] ? 3 : !x[1] ? 2 : !x[0] ? 1 : 0, q[9:8]);
   endtask : lock_chk
   // Refused command flags an error, then clear it
   task automatic err_chk();
      wb(1'b0, `REG_STATUS, 0);
      cmp("error", 1, q[1]);
      wb(1'b1, `REG_CTRL, 3);
   endtask : err_chk
   task automatic core(input logic on);
      logic [18:0] v;
      logic [2:0]  x;
      repeat (8)
      begin
         @(posedge clk);
         v = {caddr, cext, ccode, cxd};
         x = {3{on & v[2]}} & {1'b1, v[0], v[1] && (v[18:3] < 16'h4000)};
         @(posedge clk);
         cmp("blocks", x, {eblk, xblk, cblk});
      end
   endtask : core
   initial
   begin
      void'($urandom(32'hf95e99ce));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      lock_chk(3'b111);
      cmp("wdt", 1, wdt);
      wb(1'b0, 8'h24, 0);
      cmp("unmapped", 0, q);
      wb(1'b1, `REG_CTRL, 1);
      foreach (sa[i])
      begin
         run(CMD_READ_SPEC, 14'(sa[i]), 0);
         cmp("special", se[i], q);
      end
      $display("special done");
      d = 8'($urandom);
      run(CMD_WRITE_OPT, 0, d);
      run(CMD_READ_SPEC, 14'h0fc, 0);
      cmp("option", 8'hf7 | (d & 8'h08), q);
      cmp("wdt", d[3], wdt);
      run(CMD_ERASE_OPT, 0, 0);
      run(CMD_READ_SPEC, 14'h0fc, 0);
      cmp("option", 8'hff, q);
      $display("option done");
      a = 14'h0100 + 14'($urandom_range(0, 16'h3eff));
      d = 8'($urandom);
      e = 8'($urandom) & 8'hfe;
      run(CMD_WRITE_PROG, a, d);
      run(CMD_READ_PROG, a, 0);
      cmp("raw", d, q);
      run(CMD_WRITE_ENC, 14'(a[5:0]), e);
      run(CMD_READ_PROG, a, 0);
      cmp("verify", 8'(~(d ^ e)), q);
      $display("verify done");
      core(1'b0);
      run(CMD_WRITE_LB2, 0, 0);
      lock_chk(3'b100);
      run(CMD_WRITE_PROG, a, 0);
      err_chk();
      run(CMD_READ_PROG, a, 0);
      err_chk();
      run(CMD_WRITE_LB1, 0, 0);
      lock_chk(3'b100);
      run(CMD_WRITE_LB3, 0, 0);
      lock_chk(3'b000);
      core(1'b1);
      run(CMD_MASS_ERASE, 0, 0);
      lock_chk(3'b111);
      run(CMD_READ_PROG, a, 0);
      cmp("erased", 8'hff, q);
      $display("lock done");
      {rpin, ea_n, ps_n} <= 3'b100;
      repeat (4) @(posedge clk);
      cmp("rom fetch", 1, rom);
      cmp("ext fetch", 1, fext);
      n = $urandom_range(20, 60);
      rx <= 1'b0;
      repeat (n) @(posedge clk);
      rx <= 1'b1;
      repeat (4) @(posedge clk);
      wb(1'b0, `REG_BAUD, 0);
      cmp("baud", 3, {q[16], q[15:0] >= n - 1 && q[15:0] <= n + 1});
      {rpin, ea_n, ps_n} <= 3'b011;
      repeat (4) @(posedge clk);
      cmp("rom fetch", 0, rom);
      $display("loader done");
      test_done();
   end
endmodule : flash_security_test
